// >>> shared/pfse_params.svh
// Summary of operation
// - Launch erases whole sector, then verifies it
// - Completion flag sets after erase and verify, or at once on a failed launch check
// - Access error when index field not 001
// - Access error when command barred in mode
// - Access error on invalid 24-bit address
// - Access error when address not phrase aligned
// - Protection violation when sector is protected
// - Verify-error bit on any verify failure
// - Uncorrectable bit on uncorrectable verify failure
`ifndef PFSE_PARAMS_SVH
`define PFSE_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PFSE_ADDR_STAT   8'h00
`define PFSE_ADDR_IDX    8'h04
`define PFSE_ADDR_DATA   8'h08
`define PFSE_ADDR_PROT   8'h0C
`define PFSE_ADDR_CFG    8'h10
`define PFSE_ADDR_EVT    8'h14
`define PFSE_ADDR_MASK   8'h18
`define PFSE_ADDR_FAULT  8'h1C

// ****************************************
// Status bit positions
// ****************************************
`define PFSE_BIT_COMPLETE 7
`define PFSE_BIT_ACC_ERR  5
`define PFSE_BIT_PROT_VIO 4
`define PFSE_BIT_MG1      1
`define PFSE_BIT_MG0      0

// ****************************************
// Command and address constants
// ****************************************
`define PFSE_CMD_ERASE   8'h0A
`define PFSE_IDX_LAUNCH  3'b001
`define PFSE_BLOCK_BYTE  8'hFF
`define PFSE_LOW_LIMIT   16'hF800
`define PFSE_ERASED      16'hFFFF
`define PFSE_LAST_PHRASE 6'h3F
`define PFSE_RESP_OKAY   2'b00
`define PFSE_RESP_SLVERR 2'b10

`endif

// >>> shared/pfse_pkg.sv
`default_nettype none

package pfse_pkg;

    // Sequencer states, one-hot
    typedef enum logic [5:0] {
        S_IDLE  = 6'b00_0001,
        S_CHECK = 6'b00_0010,
        S_ERASE = 6'b00_0100,
        S_VREAD = 6'b00_1000,
        S_VCHK  = 6'b01_0000,
        S_DONE  = 6'b10_0000
    } pfse_state_t;

    // Whole state of the top module
    typedef struct packed {
        pfse_state_t state;
        logic        awready;
        logic        wready;
        logic        arready;
        logic        aw_full;
        logic        w_full;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        command_complete_flag;
        logic        access_error_flag;
        logic        protect_violation_flag;
        logic        mg1;
        logic        mg0;
        logic [2:0]  idx;
        logic [15:0] pw0;
        logic [15:0] pw1;
        logic [3:0]  prot;
        logic        allow;
        logic [1:0]  evt;
        logic [1:0]  mask;
        logic [15:0] fault;
        logic        irq;
        logic [1:0]  sector;
        logic [5:0]  cnt;
    } pfse_regs_t;

endpackage

`default_nettype wire

// >>> shared/pfse_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

// Phrase array port between sequencer and array
interface pfse_mem_if;
    logic        we;
    logic [7:0]  waddr;
    logic [15:0] wdata;
    logic [7:0]  raddr;
    logic [15:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// >>> core/pfse_array.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Phrase array
// ****************************************
module pfse_array (
    // Clock
    input wire logic aclk,
    // Array port
    pfse_mem_if.mem  mem
);
    logic [15:0] cells [0:255];
    logic [15:0] rdata_reg;

    // Write and registered read; no reset since contents are the array itself
    always_ff @(posedge aclk) begin
        if (mem.we) begin
            cells[mem.waddr] <= mem.wdata;
        end
        rdata_reg <= cells[mem.raddr];
    end

    assign mem.rdata = rdata_reg;
endmodule // pfse_array

`default_nettype wire

// >>> core/pfse_top.sv
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pfse_params.svh"

module pfse_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address channel
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // Write response channel
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // Read data channel
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Interrupt
    output var  logic        irq
);
    import pfse_pkg::*;

    pfse_regs_t  r_reg;
    pfse_regs_t  r_next;
    pfse_mem_if  mem_bus ();

    // ****************************************
    // Phrase array
    // ****************************************
    pfse_array u_array (
        .aclk (aclk),
        .mem  (mem_bus.mem)
    );

    // ****************************************
    // Launch checks
    // ****************************************
    logic [23:0] gaddr;
    logic        bad_idx;
    logic        bad_mode;
    logic        bad_addr;
    logic        bad_align;
    logic        bad_prot;
    logic        bad_any;
    logic [15:0] zeros;
    logic        multi_zero;

    // Checks look at the parameter words as held at launch
    assign gaddr     = {r_reg.pw0[7:0], r_reg.pw1};
    assign bad_idx   = (r_reg.idx != `PFSE_IDX_LAUNCH);
    assign bad_mode  = !r_reg.allow || (r_reg.pw0[15:8] != `PFSE_CMD_ERASE);
    assign bad_addr  = (gaddr[23:16] != `PFSE_BLOCK_BYTE)
                    || (gaddr[15:0] < `PFSE_LOW_LIMIT);
    assign bad_align = (gaddr[2:0] != 3'b000);
    assign bad_prot  = r_reg.prot[gaddr[10:9]];
    assign bad_any   = bad_idx || bad_mode || bad_addr || bad_align || bad_prot;

    // Verify: a zero bit is an unerased bit; two or more cannot be corrected
    assign zeros      = ~mem_bus.rdata;
    assign multi_zero = ((zeros & (zeros - 16'h0001)) != 16'h0000);

    // ****************************************
    // Array drive
    // ****************************************
    // Erase writes all ones; the fault mask models stuck cells for test
    always_comb begin
        mem_bus.we    = (r_reg.state == S_ERASE);
        mem_bus.waddr = {r_reg.sector, r_reg.cnt};
        mem_bus.wdata = `PFSE_ERASED & ~r_reg.fault;
        mem_bus.raddr = {r_reg.sector, r_reg.cnt};
    end

    // ****************************************
    // Next state
    // ****************************************
    logic [31:0] wm;
    logic [31:0] wv;
    logic        do_wr;
    logic        launch;
    logic [1:0]  evt_set;

    // Bus writes act first, hardware sets last so a set beats a clear
    always_comb begin
        r_next  = r_reg;
        evt_set = 2'b00;
        launch  = 1'b0;
        wm = {{8{r_reg.wstrb[3]}}, {8{r_reg.wstrb[2]}},
              {8{r_reg.wstrb[1]}}, {8{r_reg.wstrb[0]}}};
        wv = r_reg.wdata & wm;
        do_wr = r_reg.aw_full && r_reg.w_full && !r_reg.bvalid;

        // Address and data taken in either order
        if (s_axi_awvalid && r_reg.awready) begin
            r_next.aw_full = 1'b1;
            r_next.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && r_reg.wready) begin
            r_next.w_full = 1'b1;
            r_next.wdata  = s_axi_wdata;
            r_next.wstrb  = s_axi_wstrb;
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end

        // Register write
        if (do_wr) begin
            r_next.aw_full = 1'b0;
            r_next.w_full  = 1'b0;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = `PFSE_RESP_OKAY;
            case ({r_reg.awaddr[7:2], 2'b00})
                `PFSE_ADDR_STAT: begin
                    if (wv[`PFSE_BIT_ACC_ERR]) begin
                        r_next.access_error_flag = 1'b0;
                    end
                    if (wv[`PFSE_BIT_PROT_VIO]) begin
                        r_next.protect_violation_flag = 1'b0;
                    end
                    // Launch is refused while an old error is left standing
                    if (wv[`PFSE_BIT_COMPLETE] && r_reg.command_complete_flag
                        && !r_next.access_error_flag && !r_next.protect_violation_flag) begin
                        launch = 1'b1;
                    end
                end
                `PFSE_ADDR_IDX: begin
                    if (r_reg.command_complete_flag) begin
                        r_next.idx = (r_reg.idx & ~wm[2:0]) | wv[2:0];
                    end
                end
                `PFSE_ADDR_DATA: begin
                    // Parameters are frozen while a command runs
                    if (r_reg.command_complete_flag && r_reg.idx == 3'b000) begin
                        r_next.pw0 = (r_reg.pw0 & ~wm[15:0]) | wv[15:0];
                    end
                    if (r_reg.command_complete_flag && r_reg.idx == 3'b001) begin
                        r_next.pw1 = (r_reg.pw1 & ~wm[15:0]) | wv[15:0];
                    end
                end
                `PFSE_ADDR_PROT: begin
                    r_next.prot = (r_reg.prot & ~wm[3:0]) | wv[3:0];
                end
                `PFSE_ADDR_CFG: begin
                    r_next.allow = (r_reg.allow & ~wm[0]) | wv[0];
                end
                `PFSE_ADDR_EVT: begin
                    r_next.evt = r_reg.evt & ~wv[1:0];
                end
                `PFSE_ADDR_MASK: begin
                    r_next.mask = (r_reg.mask & ~wm[1:0]) | wv[1:0];
                end
                `PFSE_ADDR_FAULT: begin
                    r_next.fault = (r_reg.fault & ~wm[15:0]) | wv[15:0];
                end
                default: begin
                    r_next.bresp = `PFSE_RESP_SLVERR;
                end
            endcase
        end
        r_next.awready = !r_next.aw_full;
        r_next.wready  = !r_next.w_full;

        // Register read
        if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid  = 1'b0;
            r_next.arready = 1'b1;
        end
        if (s_axi_arvalid && r_reg.arready) begin
            r_next.arready = 1'b0;
            r_next.rvalid  = 1'b1;
            r_next.rresp   = `PFSE_RESP_OKAY;
            r_next.rdata   = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                `PFSE_ADDR_STAT: begin
                    r_next.rdata[`PFSE_BIT_COMPLETE] = r_reg.command_complete_flag;
                    r_next.rdata[`PFSE_BIT_ACC_ERR]  = r_reg.access_error_flag;
                    r_next.rdata[`PFSE_BIT_PROT_VIO] = r_reg.protect_violation_flag;
                    r_next.rdata[`PFSE_BIT_MG1]      = r_reg.mg1;
                    r_next.rdata[`PFSE_BIT_MG0]      = r_reg.mg0;
                end
                `PFSE_ADDR_IDX:   r_next.rdata[2:0] = r_reg.idx;
                `PFSE_ADDR_DATA: begin
                    if (r_reg.idx == 3'b000) begin
                        r_next.rdata[15:0] = r_reg.pw0;
                    end else if (r_reg.idx == 3'b001) begin
                        r_next.rdata[15:0] = r_reg.pw1;
                    end
                end
                `PFSE_ADDR_PROT:  r_next.rdata[3:0]  = r_reg.prot;
                `PFSE_ADDR_CFG:   r_next.rdata[0]    = r_reg.allow;
                `PFSE_ADDR_EVT:   r_next.rdata[1:0]  = r_reg.evt;
                `PFSE_ADDR_MASK:  r_next.rdata[1:0]  = r_reg.mask;
                `PFSE_ADDR_FAULT: r_next.rdata[15:0] = r_reg.fault;
                default:          r_next.rresp       = `PFSE_RESP_SLVERR;
            endcase
        end

        // Sequencer
        case (r_reg.state)
            S_IDLE: begin
                if (launch) begin
                    r_next.command_complete_flag = 1'b0;
                    r_next.mg1   = 1'b0;
                    r_next.mg0   = 1'b0;
                    r_next.state = S_CHECK;
                end
            end
            S_CHECK: begin
                r_next.sector = gaddr[10:9];
                r_next.cnt    = 6'h00;
                if (bad_idx || bad_mode || bad_addr || bad_align) begin
                    r_next.access_error_flag = 1'b1;
                end
                if (bad_prot) begin
                    r_next.protect_violation_flag = 1'b1;
                end
                if (bad_any) begin
                    r_next.command_complete_flag = 1'b1;
                    evt_set[1]   = 1'b1;
                    r_next.state = S_IDLE;
                end else begin
                    r_next.state = S_ERASE;
                end
            end
            S_ERASE: begin
                // One phrase per cycle across the sector
                r_next.cnt = r_reg.cnt + 6'h01;
                if (r_reg.cnt == `PFSE_LAST_PHRASE) begin
                    r_next.state = S_VREAD;
                end
            end
            S_VREAD: begin
                r_next.state = S_VCHK;
            end
            S_VCHK: begin
                if (zeros != 16'h0000) begin
                    r_next.mg1 = 1'b1;
                end
                if (multi_zero) begin
                    r_next.mg0 = 1'b1;
                end
                r_next.cnt = r_reg.cnt + 6'h01;
                r_next.state = (r_reg.cnt == `PFSE_LAST_PHRASE) ? S_DONE : S_VREAD;
            end
            S_DONE: begin
                r_next.command_complete_flag = 1'b1;
                evt_set[0]   = 1'b1;
                evt_set[1]   = r_reg.mg1;
                r_next.state = S_IDLE;
            end
            default: begin
                r_next.state = S_IDLE;
            end
        endcase

        // Sticky events and interrupt level
        r_next.evt = r_next.evt | evt_set;
        r_next.irq = |(r_next.evt & r_next.mask);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg         <= '0;
            r_reg.state   <= S_IDLE;
            r_reg.awready <= 1'b1;
            r_reg.wready  <= 1'b1;
            r_reg.arready <= 1'b1;
            r_reg.command_complete_flag <= 1'b1;
            r_reg.allow   <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state register
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready  = r_reg.wready;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rdata   = r_reg.rdata;
    assign s_axi_rresp   = r_reg.rresp;
    assign irq           = r_reg.irq;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_launch;
        launch && r_reg.state == S_IDLE;
    endsequence

    sequence s_check_ok;
        r_reg.state == S_CHECK && !bad_any;
    endsequence

    sequence s_check_bad;
        r_reg.state == S_CHECK && bad_any;
    endsequence

    // Launch drops the flag and starts checks
    launch_clears_a: assert property (s_launch
        |=> !r_reg.command_complete_flag && r_reg.state == S_CHECK)
        else $error("launch did not clear completion flag");

    // Good check leads to the first phrase write
    erase_starts_a: assert property (s_check_ok |=> mem_bus.we && r_reg.cnt == 6'h00)
        else $error("erase did not start after good check");

    // Flag returns only from done or failed check
    done_source_a: assert property ($rose(r_reg.command_complete_flag)
        |-> $past(r_reg.state) == S_DONE || $past(r_reg.state) == S_CHECK)
        else $error("completion flag set too early");

    // Busy holds through the first eight cycles of the erase
    busy_sweep_a: assert property (s_check_ok |=> !r_reg.command_complete_flag [*8])
        else $error("completion flag set during erase");

    // Index field check
    index_check_a: assert property (r_reg.state == S_CHECK && bad_idx
        |=> r_reg.access_error_flag)
        else $error("bad index did not raise access error");

    // Mode check
    mode_check_a: assert property (r_reg.state == S_CHECK && !r_reg.allow
        |=> r_reg.access_error_flag)
        else $error("barred mode did not raise access error");

    // Address range check
    range_check_a: assert property (r_reg.state == S_CHECK && bad_addr
        |=> r_reg.access_error_flag)
        else $error("invalid address did not raise access error");

    // Phrase alignment check
    align_check_a: assert property (r_reg.state == S_CHECK && gaddr[2:0] != 3'b000
        |=> r_reg.access_error_flag)
        else $error("misaligned address did not raise access error");

    // Protection check
    prot_check_a: assert property (r_reg.state == S_CHECK && bad_prot
        |=> r_reg.protect_violation_flag)
        else $error("protected sector did not raise violation");

    // Any unerased bit
    verify_any_a: assert property (r_reg.state == S_VCHK && zeros != 16'h0000 |=> r_reg.mg1)
        else $error("verify error not reported");

    // Uncorrectable pattern
    verify_uncorr_a: assert property (r_reg.state == S_VCHK && multi_zero |=> r_reg.mg0 && r_reg.mg1)
        else $error("uncorrectable error not reported");

    // Failed check never touches the array
    skip_erase_a: assert property (s_check_bad
        |=> r_reg.command_complete_flag && !mem_bus.we ##1 !mem_bus.we)
        else $error("failed check did not skip erase");

endmodule // pfse_top

`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfse_params.svh"

module testbench;
    import pfse_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic        aclk;
    logic        aresetn;
    logic [7:0]  s_axi_awaddr;
    logic        s_axi_awvalid;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_wvalid;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready;
    logic [7:0]  s_axi_araddr;
    logic        s_axi_arvalid;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready;
    logic        irq;
    int          failures;
    int          comparisons;
    int          cycles;
    int          test_no;

    pfse_top i_dut (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .irq           (irq)
    );

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // Whole run needs about 3000 cycles; the ceiling leaves ample slack
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 30000) begin
            failures++;
            $display("Timeout at %0t", $time);
            close_out();
        end
    end

    // ****************************************
    // Reporting
    // ****************************************
    task automatic close_out;
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask

    // ****************************************
    // Bus cycles
    // ****************************************
    // Address and data offered together; each dropped once its own ready is seen
    // Waits for the answer however long; only the hang guard ends a stuck wait
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        cmp_resp(s_axi_bresp, er);
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        cmp_resp(s_axi_rresp, er);
    endtask

    // ****************************************
    // Expected status after one command
    // ****************************************
    function automatic logic [7:0] exp_stat(input logic [2:0] idx, input logic [7:0] code,
            input logic [7:0] blk, input logic [15:0] lo, input logic allow,
            input logic [3:0] prot, input logic [15:0] fault);
        logic acc;
        logic pv;
        int   ones;
        acc  = idx != `PFSE_IDX_LAUNCH || code != `PFSE_CMD_ERASE || !allow
            || blk != `PFSE_BLOCK_BYTE || lo < `PFSE_LOW_LIMIT || lo[2:0] != 3'b000;
        // Protection is judged on its own, even when an access error also stands
        pv   = prot[lo[10:9]];
        ones = $countones(fault);
        if (acc || pv)
            return {2'b10, acc, pv, 4'h0};
        return {6'b10_0000, ones > 0, ones > 1};
    endfunction

    // Loads both parameter words, launches, polls for completion
    task automatic run(input logic [2:0] idx, input logic [7:0] code, input logic [7:0] blk,
            input logic [15:0] lo, input logic allow, input logic [3:0] prot,
            input logic [15:0] fault, input logic msk);
        logic [7:0]  es;
        logic [31:0] rd;
        int          t0;
        int          n;
        es = exp_stat(idx, code, blk, lo, allow, prot, fault);
        axw(`PFSE_ADDR_CFG, {31'h0, allow}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_PROT, {28'h0, prot}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_FAULT, {16'h0, fault}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_MASK, {30'h0, msk, 1'b0}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_EVT, 32'h0000_0003, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_STAT, 32'h0000_0030, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_IDX, 32'h0000_0000, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_DATA, {16'h0, code, blk}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_IDX, 32'h0000_0001, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_DATA, {16'h0, lo}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_IDX, {29'h0, idx}, `PFSE_RESP_OKAY);
        axw(`PFSE_ADDR_STAT, 32'h0000_0080, `PFSE_RESP_OKAY);
        t0 = cycles;
        if (!es[5] && !es[4]) begin
            axr(`PFSE_ADDR_STAT, rd, `PFSE_RESP_OKAY);
            cmp({31'h0, rd[7]}, 32'h0000_0000);
        end
        n = 0;
        do begin
            axr(`PFSE_ADDR_STAT, rd, `PFSE_RESP_OKAY);
            n++;
        end while (rd[7] !== 1'b1 && n < 200);
        if (!es[5] && !es[4])
            cmp({31'h0, (cycles - t0) >= 192}, 32'h0000_0001);
        cmp(rd, {24'h0, es});
        axr(`PFSE_ADDR_EVT, rd, `PFSE_RESP_OKAY);
        cmp(rd, {30'h0, es[5] | es[4] | es[1], !(es[5] | es[4])});
        cmp({31'h0, irq}, {31'h0, msk & (es[5] | es[4] | es[1])});
        axw(`PFSE_ADDR_EVT, 32'h0000_0003, `PFSE_RESP_OKAY);
        @(posedge aclk);
        cmp({31'h0, irq}, 32'h0000_0000);
        test_no++;
        $display("Test %0d done", test_no);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] rd;
        logic [15:0] lo;
        logic [15:0] f;
        logic [2:0]  ix;
        aresetn       = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'h0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_araddr  = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        void'($urandom(32'h1e73));
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        // Idle state and an unmapped place
        axr(`PFSE_ADDR_STAT, rd, `PFSE_RESP_OKAY);
        cmp(rd, 32'h0000_0080);
        axr(`PFSE_ADDR_CFG, rd, `PFSE_RESP_OKAY);
        cmp(rd, 32'h0000_0001);
        axr(8'h20, rd, `PFSE_RESP_SLVERR);
        axw(8'h20, 32'h0000_ffff, `PFSE_RESP_SLVERR);
        // Corner cases: good erase, each launch check, verify faults
        run(3'b001, 8'h0a, 8'hff, 16'hf800, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b000, 8'h0a, 8'hff, 16'hf800, 1'b1, 4'h0, 16'h0000, 1'b0);
        run(3'b111, 8'h0a, 8'hff, 16'hf800, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hfa00, 1'b0, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0b, 8'hff, 16'hfa00, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hfe, 16'hfa00, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hf7f8, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hfc04, 1'b1, 4'h0, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hfdf8, 1'b1, 4'h4, 16'h0000, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hfe08, 1'b1, 4'h7, 16'h0100, 1'b1);
        run(3'b001, 8'h0a, 8'hff, 16'hfff8, 1'b1, 4'h0, 16'h8001, 1'b1);
        // Random sweep over sectors, protection, faults and index
        repeat (8) begin
            lo = 16'hf800 | 16'($urandom_range(0, 255) << 3);
            f  = ($urandom_range(0, 1) == 0) ? 16'h0000 : 16'($urandom);
            ix = ($urandom_range(0, 3) == 0) ? 3'($urandom_range(0, 7)) : 3'b001;
            run(ix, 8'h0a, 8'hff, lo, 1'b1, 4'($urandom), f, 1'b1);
        end
        close_out();
    end

endmodule // testbench

`default_nettype wire
